// ===== bench/tone_receiver_host_port_tb.sv
// Testbench joining the microprocessor end and the tone device.
// Assumes the core files are compiled first; tone inputs are driven here.
`timescale 1ns/10ps
`include "tonehp_defs.svh"

module tone_receiver_host_port_tb;
   import tonehp_pkg::*;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic req_in = 1'b0, write_in = 1'b0, sel_in = 1'b0;
   logic [3:0] wdata_in = 4'h0, tone_code_in = 4'h0, rdata_out, tx_code_out;
   logic tone_valid_in = 1'b0, cp_tone_in = 1'b0, steer_input_in = 1'b0;
   logic busy_out, done_out, irq_out, early_tone_flag_out, guard_drive_out;
   logic delayed_steer_out, call_progress_mode_out, irq_enable_out;
   int bad_count = 0, cmp_count = 0;

   tonehp_bus_if bus_if();
   tonehp_device tonehp_device_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .bus(bus_if), .tone_valid_in(tone_valid_in), .tone_code_in(tone_code_in),
      .cp_tone_in(cp_tone_in), .steer_input_in(steer_input_in),
      .early_tone_flag_out(early_tone_flag_out), .guard_drive_out(guard_drive_out),
      .delayed_steer_out(delayed_steer_out), .tx_code_out(tx_code_out),
      .call_progress_mode_out(call_progress_mode_out), .irq_enable_out(irq_enable_out));
   tonehp_host tonehp_host_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .bus(bus_if), .req_in(req_in), .write_in(write_in), .sel_in(sel_in),
      .wdata_in(wdata_in), .busy_out(busy_out), .done_out(done_out),
      .rdata_out(rdata_out), .irq_out(irq_out));
   tonehp_monitor tonehp_monitor_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .cs_n(bus_if.cs_n), .rw(bus_if.rw), .register_select_line(bus_if.register_select_line),
      .phi2(bus_if.phi2), .host_data_out(bus_if.host_data_out),
      .host_data_oe(bus_if.host_data_oe), .dev_data_out(bus_if.dev_data_out),
      .dev_data_oe(bus_if.dev_data_oe), .host_data_bus(bus_if.host_data_bus),
      .irq_oe(bus_if.irq_oe), .interrupt_tone_out(bus_if.interrupt_tone_out));

   // 100 MHz clock
   always #5 sys_clk_in = ~sys_clk_in; // Stands in for the board timebase

   task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Let n edges pass, then step off the edge to sample
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   // One bus cycle through the host; the done pulse is bounded
   task automatic xfer(input logic wr, input logic sel, input logic [3:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      req_in <= 1'b1;
      write_in <= wr;
      sel_in <= sel;
      wdata_in <= wd;
      @(posedge sys_clk_in);
      req_in <= 1'b0;
      cyc(1);
      chk("busy", {3'h0, busy_out}, 4'h1);
      do begin
         cyc(1);
         n++;
      end while (done_out !== 1'b1 && n < 40);
      chk("done pulse", {3'h0, done_out}, 4'h1);
      chk("idle", {3'h0, busy_out}, 4'h0);
   endtask

   task automatic rd(input logic sel, input logic [3:0] exp, input string nm);
      xfer(1'b0, sel, 4'h0);
      chk(nm, rdata_out, exp);
   endtask

   // Hang guard; the tests need well under 10 us
   initial begin
      #50us;
      bad_count++;
      $display("[ERR] watchdog expired");
      close_out();
   end

   initial begin
      repeat (10) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      // Control and transmit writes
      xfer(1'b1, `TONEHP_SEL_CTRL, 4'h1);
      chk("irq enable", {3'h0, irq_enable_out}, 4'h1);
      chk("cp mode", {3'h0, call_progress_mode_out}, 4'h0);
      xfer(1'b1, `TONEHP_SEL_DATA, 4'ha);
      chk("tx code", tx_code_out, 4'ha);
      xfer(1'b1, `TONEHP_SEL_DATA, 4'h5);
      chk("tx code", tx_code_out, 4'h5);
      $display("test writes done");
      // Tone pair, registration, delayed flag
      @(posedge sys_clk_in);
      tone_code_in <= 4'h6;
      tone_valid_in <= 1'b1;
      cyc(6);
      chk("early", {3'h0, early_tone_flag_out}, 4'h1);
      chk("guard idle", {3'h0, guard_drive_out}, 4'h0);
      @(posedge sys_clk_in);
      steer_input_in <= 1'b1;
      cyc(6);
      chk("guard", {3'h0, guard_drive_out}, 4'h1);
      chk("flag early", {3'h0, delayed_steer_out}, 4'h0);
      cyc(25);
      chk("flag", {3'h0, delayed_steer_out}, 4'h1);
      chk("irq", {3'h0, irq_out}, 4'h1);
      rd(`TONEHP_SEL_CTRL, 4'h3, "status");
      rd(`TONEHP_SEL_DATA, 4'h6, "rx code");
      // Momentary loss of the pair, new code ignored until re-armed
      @(posedge sys_clk_in);
      tone_valid_in <= 1'b0;
      tone_code_in <= 4'h9;
      cyc(5);
      chk("early drop", {3'h0, early_tone_flag_out}, 4'h0);
      chk("guard drop", {3'h0, guard_drive_out}, 4'h0);
      @(posedge sys_clk_in);
      tone_valid_in <= 1'b1;
      cyc(6);
      rd(`TONEHP_SEL_DATA, 4'h6, "rx held");
      @(posedge sys_clk_in);
      steer_input_in <= 1'b0;
      cyc(8);
      chk("flag clear", {3'h0, delayed_steer_out}, 4'h0);
      chk("irq clear", {3'h0, irq_out}, 4'h0);
      @(posedge sys_clk_in);
      steer_input_in <= 1'b1;
      cyc(35);
      rd(`TONEHP_SEL_DATA, 4'h9, "rx new");
      @(posedge sys_clk_in);
      steer_input_in <= 1'b0;
      tone_valid_in <= 1'b0;
      $display("test steering done");
      // Call-progress square wave, then with interrupts off
      xfer(1'b1, `TONEHP_SEL_CTRL, 4'h3);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk_in);
         cp_tone_in <= ~i[0];
         cyc(7);
         chk("cp wave", {3'h0, irq_out}, {3'h0, ~i[0]});
      end
      xfer(1'b1, `TONEHP_SEL_CTRL, 4'h2);
      @(posedge sys_clk_in);
      cp_tone_in <= 1'b1;
      cyc(7);
      chk("cp masked", {3'h0, irq_out}, 4'h0);
      $display("test call progress done");
      close_out();
   end
endmodule // tone_receiver_host_port_tb

// ===== bench/tonehp_monitor.sv
// Checker for the pins between the tone device and the microprocessor end.
// Assumes it is instantiated beside the link interface, fed its signals.
`timescale 1ns/10ps

module tonehp_monitor (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Link pins
   input wire logic cs_n,
   input wire logic rw,
   input wire logic register_select_line,
   input wire logic phi2,
   input wire logic [3:0] host_data_out,
   input wire logic host_data_oe,
   input wire logic [3:0] dev_data_out,
   input wire logic dev_data_oe,
   input wire logic [3:0] host_data_bus,
   input wire logic irq_oe,
   input wire logic interrupt_tone_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   // Device drive only when selected and asked to read
   chk_read_needs_cs: assert property (dev_data_oe |-> !cs_n)
      else $error("device drives bus while deselected");
   chk_read_needs_rw: assert property (dev_data_oe |-> rw)
      else $error("device drives bus on a write");
   chk_write_dir: assert property (host_data_oe |-> !rw)
      else $error("host drives bus on a read");
   chk_bus_owner: assert property (dev_data_oe |-> !host_data_oe
      && host_data_bus == dev_data_out)
      else $error("data bus contention or wrong read value");
   // Read drive follows the bus clock with a fixed lag
   chk_oe_rise: assert property ($rose(phi2) && !cs_n && rw |-> ##3 dev_data_oe)
      else $error("read drive late after bus clock rise");
   chk_oe_fall: assert property ($fell(phi2) |-> ##3 !dev_data_oe)
      else $error("read drive kept after bus clock fall");
   // High phase length and stable qualifiers during it
   chk_phase_len: assert property ($rose(phi2) |=> phi2 [*8] ##1 phi2 ##1 !phi2)
      else $error("bus clock high phase not ten cycles");
   chk_phase_hold: assert property (phi2 && $past(phi2) |-> $stable(cs_n) && $stable(rw)
      && $stable(register_select_line) && $stable(host_data_out))
      else $error("qualifiers moved in high phase");
   chk_select_hold: assert property ($fell(phi2) |-> !cs_n [*4])
      else $error("select released too soon");
   // Open drain: pin only ever pulled low
   chk_irq_drain: assert property (interrupt_tone_out == !irq_oe)
      else $error("interrupt pin not open drain");
endmodule // tonehp_monitor

// ===== core/tonehp_bus_if.sv
// Pin-level link between the microprocessor end and the tone device.
// Resolves the shared data bus and the open-drain interrupt line.
`timescale 1ns/10ps
`include "tonehp_defs.svh"

interface tonehp_bus_if;
   // Host-driven control pins
   logic cs_n;
   logic rw;
   logic register_select_line;
   logic phi2;
   // Shared data bus, both drivers
   logic [3:0] host_data_out;
   logic host_data_oe;
   logic [3:0] dev_data_out;
   logic dev_data_oe;
   logic [3:0] host_data_bus;
   // Open-drain interrupt, device only pulls low
   logic irq_oe;
   logic interrupt_tone_out;

   // Pull-ups model the idle bus and the released interrupt
   assign host_data_bus = dev_data_oe ? dev_data_out :
                          host_data_oe ? host_data_out : `TONEHP_BUS_IDLE;
   assign interrupt_tone_out = irq_oe ? 1'b0 : 1'b1;

   modport dev (
      input cs_n, rw, register_select_line, phi2, host_data_bus,
      output dev_data_out, dev_data_oe, irq_oe
   );

   modport host (
      output cs_n, rw, register_select_line, phi2, host_data_out, host_data_oe,
      input host_data_bus, interrupt_tone_out
   );
endinterface // tonehp_bus_if

// ===== core/tonehp_defs.svh
// Timing counts and register map constants for the tone receiver host port.
// Assumes a 100 MHz system clock on both ends of the link.
`ifndef TONEHP_DEFS_SVH
`define TONEHP_DEFS_SVH

// System clock period in ns
`define TONEHP_CLK_NS 10
// Settling delay from registration to delayed-steering flag, in ns
`define TONEHP_SETTLE_NS 200
`define TONEHP_SETTLE_CYC ((`TONEHP_SETTLE_NS + `TONEHP_CLK_NS - 1) / `TONEHP_CLK_NS)

// Bus phase clock shape made by the host, in system cycles
`define TONEHP_PH_SETUP_CYC 4
`define TONEHP_PH_HIGH_CYC 10
`define TONEHP_PH_HOLD_CYC 4

// Register select values (register_select_line level)
`define TONEHP_SEL_DATA 1'b0
`define TONEHP_SEL_CTRL 1'b1

// Control register fields (write, select high)
`define TONEHP_CTRL_IRQ_EN_BIT 0
`define TONEHP_CTRL_CP_MODE_BIT 1
`define TONEHP_CTRL_RESET 2'h0

// Status register fields (read, select high)
`define TONEHP_STAT_DSF_BIT 0
`define TONEHP_STAT_EARLY_BIT 1

// Data bus reset and idle values
`define TONEHP_DATA_RESET 4'h0
`define TONEHP_BUS_IDLE 4'hf

`endif

// ===== core/tonehp_device.sv
// Device end of the tone receiver host port: bus slave, steering, interrupt.
// Assumes the host end drives the link pins; those are synchronised here.
//
// Contract
// - Chip select low addresses device, high ignored.
// - Direction line picks read drive or write accept.
// - Register data moves over four-line data bus.
// - Select line plus direction picks the register.
// - Transfers are timed to host bus clock.
// - Interrupt pin only pulls low, never high.
// - Call-progress mode puts tone square wave on pin.
// - Early flag rises on valid tone pair.
// - Early flag drops on any loss, even momentary.
// - Steering rise registers pair into output latch.
// - Steering fall re-arms for next tone pair.
// - Guard output depends on early flag, steering level.
// - Board supplies crystal timebase for tone oscillator.
// - Registration stores 4-bit code in receive register.
// - Guard stays high while early flag high; here only from registration until steering falls.
// - Delayed-steering flag set after settling delay.
// - Interrupt mode pulls pin low on flag.
`timescale 1ns/10ps
`include "tonehp_defs.svh"

module tonehp_device
   import tonehp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Link to the microprocessor
   tonehp_bus_if.dev bus,
   // Detector and analog front end side
   input wire logic tone_valid_in,
   input wire logic [3:0] tone_code_in,
   input wire logic cp_tone_in,
   input wire logic steer_input_in,
   // Steering pin outputs and flags
   output logic early_tone_flag_out,
   output logic guard_drive_out,
   output logic delayed_steer_out,
   // Transmit side and mode outputs
   output logic [3:0] tx_code_out,
   output logic call_progress_mode_out,
   output logic irq_enable_out
);

   localparam int SYNC_W = 11;
   localparam int SETTLE_W = 8;
   localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(`TONEHP_SETTLE_CYC - 1);
   // Idle pin levels: bus pulled high, deselected, read direction
   localparam logic [SYNC_W-1:0] SYNC_IDLE = {`TONEHP_BUS_IDLE, 7'h60};

   // Raw inputs from outside this clock domain
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic ph_prev_q;

   logic [3:0] d_s;
   logic cs_n_s;
   logic rw_s;
   logic rs_s;
   logic ph_s;
   logic st_s;
   logic tv_s;
   logic cpt_s;

   // Bus decode
   logic sel_s;
   logic rd_phase;
   logic wr_commit;
   logic wr_data;
   logic wr_ctrl;
   logic [3:0] status_word;
   logic [3:0] rd_word;

   // Registers
   logic [3:0] rx_q;
   logic [3:0] tx_q;
   logic [3:0] tx_d;
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic [3:0] dout_q;
   logic doe_q;
   logic irq_oe_q;
   logic irq_oe_d;

   // Steering
   tonehp_steer_t st_q;
   tonehp_steer_t st_d;
   logic [SETTLE_W-1:0] cnt_q;
   logic [SETTLE_W-1:0] cnt_d;
   logic early_q;
   logic guard_q;
   logic guard_d;
   logic dsf_q;
   logic dsf_d;
   logic dsf_set;
   logic dsf_clr;
   logic do_register;

   // Every pin and async detector level except tone_code_in enters through two flops
   assign raw_in = {bus.host_data_bus, bus.cs_n, bus.rw, bus.register_select_line,
                    bus.phi2, steer_input_in, tone_valid_in, cp_tone_in};

   // Two-stage synchroniser; reset to idle so no false select follows
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   assign d_s = sync2_q[10:7];
   assign cs_n_s = sync2_q[6];
   assign rw_s = sync2_q[5];
   assign rs_s = sync2_q[4];
   assign ph_s = sync2_q[3];
   assign st_s = sync2_q[2];
   assign tv_s = sync2_q[1];
   assign cpt_s = sync2_q[0];

   // Bus phase clock edges; all bus lines share the same sync delay
   assign sel_s = ~cs_n_s;
   assign rd_phase = ph_s & sel_s & rw_s;
   assign wr_commit = ph_prev_q & ~ph_s & sel_s & ~rw_s;
   assign wr_data = wr_commit & (rs_s == `TONEHP_SEL_DATA);
   assign wr_ctrl = wr_commit & (rs_s == `TONEHP_SEL_CTRL);

   // Read mux: receive data or status
   assign status_word = {2'h0, early_q, dsf_q};
   assign rd_word = (rs_s == `TONEHP_SEL_DATA) ? rx_q : status_word;

   // Register writes land at the end of the high phase
   assign tx_d = wr_data ? d_s : tx_q;
   assign ctrl_d = wr_ctrl ? d_s[1:0] : ctrl_q;

   // Pin pulled low only; wave in call-progress mode, else flag
   assign irq_oe_d = ctrl_q[`TONEHP_CTRL_IRQ_EN_BIT] &
                     (ctrl_q[`TONEHP_CTRL_CP_MODE_BIT] ? cpt_s : dsf_q);

   // Bus side registers
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ph_prev_q <= 1'b0;
         tx_q <= `TONEHP_DATA_RESET;
         ctrl_q <= `TONEHP_CTRL_RESET;
         dout_q <= `TONEHP_DATA_RESET;
         doe_q <= 1'b0;
         irq_oe_q <= 1'b0;
      end else begin
         ph_prev_q <= ph_s;
         tx_q <= tx_d;
         ctrl_q <= ctrl_d;
         dout_q <= rd_word;
         doe_q <= rd_phase;
         irq_oe_q <= irq_oe_d;
      end
   end

   // Steering sequencer: arm, settle, hold until steering falls
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      do_register = 1'b0;
      dsf_set = 1'b0;
      dsf_clr = 1'b0;
      case (st_q)
         TONEHP_ST_ARMED: begin
            if (st_s && tv_s) begin
               do_register = 1'b1;
               cnt_d = '0;
               st_d = TONEHP_ST_SETTLE;
            end
         end
         TONEHP_ST_SETTLE: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == SETTLE_LAST) begin
               dsf_set = 1'b1;
               st_d = TONEHP_ST_HELD;
            end
            if (!st_s) begin
               dsf_clr = 1'b1;
               st_d = TONEHP_ST_ARMED;
            end
         end
         TONEHP_ST_HELD: begin
            if (!st_s) begin
               dsf_clr = 1'b1;
               st_d = TONEHP_ST_ARMED;
            end
         end
         default: begin
            st_d = TONEHP_ST_ARMED;
         end
      endcase
   end

   // A late settle beats a same-cycle clear so no pair is lost
   assign dsf_d = dsf_set | (dsf_q & ~dsf_clr);

   // Guard drives high from registration while early flag holds
   assign guard_d = ((st_q != TONEHP_ST_ARMED) | do_register) & tv_s;

   // Steering state and latch
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q <= TONEHP_ST_ARMED;
         cnt_q <= '0;
         rx_q <= `TONEHP_DATA_RESET;
         early_q <= 1'b0;
         guard_q <= 1'b0;
         dsf_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         early_q <= tv_s;
         guard_q <= guard_d;
         dsf_q <= dsf_d;
         if (do_register) begin
            rx_q <= tone_code_in;
         end
      end
   end

   // Outputs, each straight from a flop
   assign bus.dev_data_out = dout_q;
   assign bus.dev_data_oe = doe_q;
   assign bus.irq_oe = irq_oe_q;
   assign early_tone_flag_out = early_q;
   assign guard_drive_out = guard_q;
   assign delayed_steer_out = dsf_q;
   assign tx_code_out = tx_q;
   assign call_progress_mode_out = ctrl_q[`TONEHP_CTRL_CP_MODE_BIT];
   assign irq_enable_out = ctrl_q[`TONEHP_CTRL_IRQ_EN_BIT];

endmodule // tonehp_device

// ===== core/tonehp_host.sv
// Microprocessor end: runs one bus cycle per request on the link.
// Assumes the device samples the pins through its own synchronisers.
`timescale 1ns/10ps
`include "tonehp_defs.svh"

module tonehp_host
   import tonehp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Link to the device
   tonehp_bus_if.host bus,
   // Command port
   input wire logic req_in,
   input wire logic write_in,
   input wire logic sel_in,
   input wire logic [3:0] wdata_in,
   // Answer port
   output logic busy_out,
   output logic done_out,
   output logic [3:0] rdata_out,
   output logic irq_out
);

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(`TONEHP_PH_SETUP_CYC - 1);
   localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(`TONEHP_PH_HIGH_CYC - 1);
   localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(`TONEHP_PH_HOLD_CYC - 1);

   tonehp_hstate_t hs_q;
   tonehp_hstate_t hs_d;
   logic [CNT_W-1:0] cnt_q;
   logic cnt_end;
   logic [CNT_W-1:0] last_cnt;
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic cs_n_q;
   logic rw_q;
   logic rs_q;
   logic ph_q;
   logic [3:0] hd_q;
   logic hoe_q;
   logic done_q;
   logic busy_q;
   logic irq_q;
   logic [3:0] rdata_q;
   logic take;
   logic capture;

   // Phase lengths selected per state
   assign last_cnt = (hs_q == TONEHP_H_SETUP) ? SETUP_LAST :
                     (hs_q == TONEHP_H_HIGH) ? HIGH_LAST : HOLD_LAST;
   assign cnt_end = (cnt_q == last_cnt);
   assign take = (hs_q == TONEHP_H_IDLE) & req_in;
   assign capture = (hs_q == TONEHP_H_HIGH) & cnt_end & rw_q;

   // Bus cycle sequencer; lines stay put through the high phase
   always_comb begin
      hs_d = hs_q;
      case (hs_q)
         TONEHP_H_IDLE: if (req_in) hs_d = TONEHP_H_SETUP;
         TONEHP_H_SETUP: if (cnt_end) hs_d = TONEHP_H_HIGH;
         TONEHP_H_HIGH: if (cnt_end) hs_d = TONEHP_H_HOLD;
         TONEHP_H_HOLD: if (cnt_end) hs_d = TONEHP_H_IDLE;
         default: hs_d = TONEHP_H_IDLE;
      endcase
   end

   // Data and interrupt pins are resynchronised; reset to released levels
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_q <= {1'b1, `TONEHP_BUS_IDLE};
         sync2_q <= {1'b1, `TONEHP_BUS_IDLE};
      end else begin
         sync1_q <= {bus.interrupt_tone_out, bus.host_data_bus};
         sync2_q <= sync1_q;
      end
   end

   // Pin drivers and answers
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hs_q <= TONEHP_H_IDLE;
         cnt_q <= '0;
         cs_n_q <= 1'b1;
         rw_q <= 1'b1;
         rs_q <= 1'b0;
         ph_q <= 1'b0;
         hd_q <= `TONEHP_DATA_RESET;
         hoe_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= `TONEHP_DATA_RESET;
      end else begin
         hs_q <= hs_d;
         busy_q <= (hs_d != TONEHP_H_IDLE);
         irq_q <= ~sync2_q[4]; // Pin low means request
         cnt_q <= (hs_d != hs_q) ? '0 : cnt_q + 1'b1;
         done_q <= (hs_q == TONEHP_H_HOLD) & cnt_end;
         ph_q <= (hs_d == TONEHP_H_HIGH);
         if (take) begin
            cs_n_q <= 1'b0;
            rw_q <= ~write_in;
            rs_q <= sel_in;
            hd_q <= wdata_in;
            hoe_q <= write_in;
         end else if (hs_d == TONEHP_H_IDLE) begin
            cs_n_q <= 1'b1;
            rw_q <= 1'b1;
            hoe_q <= 1'b0;
         end
         if (capture) begin
            rdata_q <= sync2_q[3:0];
         end
      end
   end

   assign bus.cs_n = cs_n_q;
   assign bus.rw = rw_q;
   assign bus.register_select_line = rs_q;
   assign bus.phi2 = ph_q;
   assign bus.host_data_out = hd_q;
   assign bus.host_data_oe = hoe_q;
   assign busy_out = busy_q;
   assign done_out = done_q;
   assign rdata_out = rdata_q;
   assign irq_out = irq_q;

endmodule // tonehp_host

// ===== core/tonehp_pkg.sv
// Types shared by both ends of the tone receiver host port.
// Constants live in tonehp_defs.svh.
package tonehp_pkg;

   // Steering sequencer in the device
   typedef enum logic [1:0] {
      TONEHP_ST_ARMED,
      TONEHP_ST_SETTLE,
      TONEHP_ST_HELD
   } tonehp_steer_t;

   // Bus cycle sequencer in the host
   typedef enum logic [1:0] {
      TONEHP_H_IDLE,
      TONEHP_H_SETUP,
      TONEHP_H_HIGH,
      TONEHP_H_HOLD
   } tonehp_hstate_t;

endpackage
